// ==== src/memref_regs.svh ====
/*
  Register offsets, field positions, opcodes, reset values and timing counts
  for the memory reference sequencer.
  Assumes a 40 ns machine clock and a 3-bit register port address.
*/
`ifndef MEMREF_REGS_SVH
`define MEMREF_REGS_SVH

// ----------------------------------------------------------------------
// register port map
// ----------------------------------------------------------------------
`define REG_CTRL      3'h0
`define REG_STAT      3'h1
`define REG_PC        3'h2
`define REG_ACCA      3'h3
`define REG_ACCB      3'h4
`define REG_MAR       3'h5
`define REG_MDR       3'h6
`define CTRL_RUN      0
`define STAT_PH_LSB   0
`define STAT_PER_LSB  2
`define STAT_CARRY    5
`define STAT_IDLE     6
`define STAT_IR_LSB   10
`define WORD_RST      16'h0000

// ----------------------------------------------------------------------
// instruction fields (instruction register keeps word bits 15..10)
// ----------------------------------------------------------------------
`define IR_IND        5
`define IR_ACC        1
`define IR_PAGE       0
`define OP_AND        4'h2
`define OP_JSUB       4'h3
`define OP_XOR        4'h4
`define OP_ORIN       4'h6
`define OP_INCSKP     4'h7
`define OPG_ADD       3'h4
`define OPG_CMP       3'h5
`define OPG_LOAD      3'h6
`define OPG_STORE     3'h7

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_NS        40
`define WR_EXTRA_NS   500
`define WR_EXTRA_CYC  ((`WR_EXTRA_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== src/memref_pkg.sv ====
/*
  Types shared by the memory reference sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package memref_pkg;

  typedef enum logic [1:0]
  {
    PH_FETCH = 2'b01,
    PH_IND   = 2'b10,
    PH_EXEC  = 2'b11
  } phase_t;

  typedef logic [2:0]  period_t;
  typedef logic [15:0] word_t;
  typedef logic [5:0]  instr_t;

endpackage

// ==== src/memref_phase_sequencer.sv ====
/*
  Phase and time-period sequencer for memory reference instructions:
  fetch decisions, indirect phase and execute phase, with working registers.
  Assumes a core memory on the same clock: a one-cycle read strobe returns
  data in the next cycle; a one-cycle write strobe stores the data word.
*/
// Overview of operation
// - indirect phase clears data register at T1, then reads word at address
// - indirect T6-T7 copy all 16 data bits into address register
// - indirect word bit 15 set repeats indirect; clear moves to execute
// - execute starts by clearing data register; instruction register holds
// - and: A and memory data into A at T3-T4
// - execute T6-T7 program counter plus one into counter and address
// - exclusive-or: A xor memory data into A at T3-T4
// - execute phase ends by returning to fetch phase
// - inclusive-or: same as exclusive-or but stores A or memory data
// - subroutine jump inhibits read data, loads counter plus one at T1-T2
// - subroutine jump moves address register into counter at T3
// - increment-skip delays write, increments data register at T3-T4
// - all-ones rollover sets carry from adder carry-out
// - increment-skip write starts T5, which stretches by 13 extra cycles (520 ns, 0.5 us rounded up to whole cycles)
// - carry set at T6-T7 advances counter and address by two
// - carry clears at start of next phase
// - add: bit 11 picks A or B; accumulator plus data stored back
// - compare: selected accumulator xor data; non-zero sets carry
// - load: data register into A or B at T3-T4
// - store inhibits read data, loads A or B into data register at T1-T2
// - fetch end: memory reference word bit 15 zero sets execute, else indirect; other words stay in fetch
// - page bit zero clears address bits 10-15 after address field load
`timescale 1ns/10ps
`default_nettype none
`include "memref_regs.svh"

module memref_phase_sequencer
  import memref_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic [15:0] mem_rdata_i,
  output logic      [15:0] mem_addr_o,
  output logic      [15:0] mem_wdata_o,
  output logic             mem_read_o,
  output logic             mem_write_o,
  output logic      [1:0]  phase_o,
  output logic      [2:0]  period_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  phase_t     phase_reg;
  period_t    period_reg;
  logic [3:0] wait_reg;
  logic       run_reg, carry_reg, rd_reg, wr_reg;
  word_t      p_reg, m_reg, t_reg, a_reg, b_reg, rdata_reg;
  instr_t     ir_reg;
  function automatic logic [16:0] add16(input word_t x, input word_t y, input logic cin);
    add16 = {1'b0, x} + {1'b0, y} + {16'h0000, cin};
  endfunction

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic [3:0] op4;
  logic [2:0] op3;
  logic is_and, is_xor, is_orin, is_jsub, is_incskp;
  logic is_add, is_cmp, is_load, is_store, is_memref;
  logic exec, idle, stall, step, a_wr, b_wr;
  word_t acc, alu;
  logic [16:0] pc_sum, alu_sum, inc_sum;

  assign op4       = ir_reg[4:1];
  assign op3       = ir_reg[4:2];
  assign is_and    = op4 == `OP_AND;
  assign is_xor    = op4 == `OP_XOR;
  assign is_orin   = op4 == `OP_ORIN;
  assign is_jsub   = op4 == `OP_JSUB;
  assign is_incskp = op4 == `OP_INCSKP;
  assign is_add    = op3 == `OPG_ADD;
  assign is_cmp    = op3 == `OPG_CMP;
  assign is_load   = op3 == `OPG_LOAD;
  assign is_store  = op3 == `OPG_STORE;
  assign is_memref = ir_reg[4] | is_and | is_xor | is_orin | is_jsub | is_incskp;
  assign exec      = phase_reg == PH_EXEC;
  assign acc       = ir_reg[`IR_ACC] ? b_reg : a_reg;
  assign pc_sum    = add16(p_reg, 16'h0001, carry_reg);
  assign alu_sum   = add16(acc, t_reg, 1'b0);
  assign inc_sum   = add16(t_reg, 16'h0001, 1'b0);

  // the sequencer parks only at the start of a fetch, so an instruction
  // is never cut in half when software stops the machine
  assign idle  = !run_reg && phase_reg == PH_FETCH && period_reg == 3'h0;
  assign stall = exec && is_incskp && period_reg == 3'h5 && wait_reg != 4'(`WR_EXTRA_CYC);
  assign step  = !idle && !stall;

  // and/xor/or carry bit 11 clear in their opcode, so A is always the target
  assign a_wr = exec && (is_and | is_xor | is_orin | is_add | is_load) && !ir_reg[`IR_ACC];
  assign b_wr = exec && (is_add | is_load) && ir_reg[`IR_ACC];

  always_comb
  begin
    alu = t_reg;
    if (is_and)
      alu = acc & t_reg;
    else if (is_xor)
      alu = acc ^ t_reg;
    else if (is_orin)
      alu = acc | t_reg;
    else if (is_add)
      alu = alu_sum[15:0];
  end

  // ----------------------------------------------------------------------
  // period and phase sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      period_reg <= 3'h0;
    else if (step)
      period_reg <= period_reg + 3'h1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      wait_reg <= 4'h0;
    else if (stall)
      wait_reg <= wait_reg + 4'h1;
    else
      wait_reg <= 4'h0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      phase_reg <= PH_FETCH;
    else if (step && period_reg == 3'h7)
    begin
      case (phase_reg)
        PH_FETCH: if (is_memref)
                    phase_reg <= ir_reg[`IR_IND] ? PH_IND : PH_EXEC;
        PH_IND:   phase_reg <= t_reg[15] ? PH_IND : PH_EXEC;
        PH_EXEC:  phase_reg <= PH_FETCH;
        default:  phase_reg <= PH_FETCH;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // memory strobes
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      rd_reg <= 1'b0;
    else
      rd_reg <= step && period_reg == 3'h0;
  end

  // increment-skip defers its write so the new value exists before storing
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      wr_reg <= 1'b0;
    else if (exec && is_incskp)
      wr_reg <= step && period_reg == 3'h4;
    else
      wr_reg <= step && period_reg == 3'h3;
  end

  // ----------------------------------------------------------------------
  // memory data register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      t_reg <= `WORD_RST;
    else if (idle && reg_wr_i && reg_addr_i == `REG_MDR)
      t_reg <= reg_wdata_i;
    else if (step)
    begin
      case (period_reg)
        3'h0: if (phase_reg != PH_IND)
                t_reg <= `WORD_RST;
        3'h1: if (phase_reg == PH_IND)
                t_reg <= `WORD_RST;
              else if (exec && is_jsub)
                t_reg <= pc_sum[15:0];
              else if (exec && is_store)
                t_reg <= acc;
        3'h2: if (!(exec && (is_jsub || is_store)))
                t_reg <= mem_rdata_i;
        3'h3: if (exec && is_incskp)
                t_reg <= inc_sum[15:0];
        default: t_reg <= t_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // instruction register: only loaded during fetch
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      ir_reg <= 6'h00;
    else if (step && phase_reg == PH_FETCH && period_reg == 3'h1)
      ir_reg <= 6'h00;
    else if (step && phase_reg == PH_FETCH && period_reg == 3'h2)
      ir_reg <= mem_rdata_i[15:10];
  end

  // ----------------------------------------------------------------------
  // accumulators
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      a_reg <= `WORD_RST;
    else if (idle && reg_wr_i && reg_addr_i == `REG_ACCA)
      a_reg <= reg_wdata_i;
    else if (step && period_reg == 3'h3 && a_wr)
      a_reg <= alu;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      b_reg <= `WORD_RST;
    else if (idle && reg_wr_i && reg_addr_i == `REG_ACCB)
      b_reg <= reg_wdata_i;
    else if (step && period_reg == 3'h3 && b_wr)
      b_reg <= alu;
  end

  // ----------------------------------------------------------------------
  // carry: cleared at each phase start, set wins by never sharing a period
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      carry_reg <= 1'b0;
    else if (step && period_reg == 3'h0)
      carry_reg <= 1'b0;
    else if (step && exec && period_reg == 3'h3)
    begin
      if (is_incskp)
        carry_reg <= carry_reg | inc_sum[16];
      else if (is_cmp)
        carry_reg <= carry_reg | (|(acc ^ t_reg));
    end
  end

  // ----------------------------------------------------------------------
  // program counter and address register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      p_reg <= `WORD_RST;
    else if (idle && reg_wr_i && reg_addr_i == `REG_PC)
      p_reg <= reg_wdata_i;
    else if (step && exec && is_jsub && period_reg == 3'h3)
      p_reg <= m_reg;
    else if (step && period_reg == 3'h6 && (exec || !is_memref) && phase_reg != PH_IND)
      p_reg <= pc_sum[15:0];
  end

  // the address register follows the counter on fetch so that the page
  // bits it keeps are those of the current instruction
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      m_reg <= `WORD_RST;
    else if (idle && reg_wr_i && reg_addr_i == `REG_PC)
      m_reg <= reg_wdata_i;
    else if (idle && reg_wr_i && reg_addr_i == `REG_MAR)
      m_reg <= reg_wdata_i;
    else if (step && period_reg == 3'h6)
    begin
      case (phase_reg)
        PH_IND:   m_reg <= t_reg;
        PH_EXEC:  m_reg <= pc_sum[15:0];
        PH_FETCH: if (is_memref)
                    m_reg <= {ir_reg[`IR_PAGE] ? m_reg[15:10] : 6'h00, t_reg[9:0]};
                  else
                    m_reg <= pc_sum[15:0];
        default:  m_reg <= m_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      run_reg <= 1'b0;
    else if (reg_wr_i && reg_addr_i == `REG_CTRL)
      run_reg <= reg_wdata_i[`CTRL_RUN];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      rdata_reg <= `WORD_RST;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `REG_CTRL: rdata_reg <= {15'h0000, run_reg};
        `REG_STAT: rdata_reg <= {ir_reg, 3'h0, idle, carry_reg, period_reg, phase_reg};
        `REG_PC:   rdata_reg <= p_reg;
        `REG_ACCA: rdata_reg <= a_reg;
        `REG_ACCB: rdata_reg <= b_reg;
        `REG_MAR:  rdata_reg <= m_reg;
        `REG_MDR:  rdata_reg <= t_reg;
        default:   rdata_reg <= `WORD_RST;
      endcase
    end
    else
      rdata_reg <= `WORD_RST;
  end

  assign reg_rdata_o = rdata_reg;
  assign mem_addr_o  = m_reg;
  assign mem_wdata_o = t_reg;
  assign mem_read_o  = rd_reg;
  assign mem_write_o = wr_reg;
  assign phase_o     = phase_reg;
  assign period_o    = period_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_ind_clear_t: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step && phase_reg == PH_IND && period_reg == 3'h1 |=> t_reg == 16'h0000)
    else $error("indirect data register not cleared");
  a_ind_copy_addr: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step && phase_reg == PH_IND && period_reg == 3'h6 |=> m_reg == $past(t_reg))
    else $error("indirect word not copied to address");
  a_ind_repeat: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step && phase_reg == PH_IND && period_reg == 3'h7 |=>
      phase_reg == ($past(t_reg[15]) ? PH_IND : PH_EXEC))
    else $error("wrong phase after indirect");
  a_ir_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    phase_reg != PH_FETCH |=> $stable(ir_reg))
    else $error("instruction register changed outside fetch");
  a_and_store: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step && exec && is_and && period_reg == 3'h3 |=>
      a_reg == ($past(a_reg) & $past(t_reg)))
    else $error("and result wrong");
  a_pc_advance: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step && exec && period_reg == 3'h6 |=>
      p_reg == $past(p_reg) + 16'h0001 + {15'h0000, $past(carry_reg)} && m_reg == p_reg)
    else $error("counter advance wrong");
  a_exec_fetch: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step && exec && period_reg == 3'h7 |=> phase_reg == PH_FETCH && period_reg == 3'h0)
    else $error("execute did not return to fetch");
  a_late_write: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step && exec && is_incskp && period_reg == 3'h4 |=>
      mem_write_o ##13 period_reg == 3'h5 ##1 period_reg == 3'h6)
    else $error("deferred write timing wrong");
  a_carry_clear: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step && period_reg == 3'h0 |=> !carry_reg)
    else $error("carry not cleared at phase start");
  a_cmp_skip: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step && exec && is_cmp && period_reg == 3'h3 && acc != t_reg |=> carry_reg ##3 carry_reg)
    else $error("compare mismatch did not set carry");
  a_jsub_ret: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step && exec && is_jsub && period_reg == 3'h1 |=>
      t_reg == $past(p_reg) + 16'h0001 ##1 t_reg == $past(t_reg))
    else $error("return address wrong");

endmodule

`default_nettype wire

// ==== sim/core_memory_model.sv ====
/*
  Behavioural core memory on the machine clock, facing the sequencer.
  Assumes a one-cycle read strobe and read data wanted in the next cycle only.
*/
`timescale 1ns/10ps
`default_nettype none

module core_memory_model
(
  input  wire logic        ref_clk_i,
  input  wire logic        mem_read_i,
  input  wire logic        mem_write_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [15:0] mem_wdata_i,
  output logic      [15:0] mem_rdata_o
);
  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // only eleven address bits decode: higher bits alias, keep tests below 2k
  logic [15:0] mem [0:2047];
  int          i;

  initial
  begin
    for (i = 0; i < 2048; i++)
      mem[i] = 16'h0000;
    mem_rdata_o = 16'h0000;
  end

  // ----------------------------------------------------------------------
  // read and write portions
  // ----------------------------------------------------------------------
  // no slow answer is legal here; off the answer cycle the bus shows the
  // inverse of its last value so that a late sample is caught
  always @(posedge ref_clk_i)
  begin
    if (mem_read_i)
      mem_rdata_o <= mem[mem_addr_i[10:0]];
    else
      mem_rdata_o <= ~mem_rdata_o;
    if (mem_write_i)
      mem[mem_addr_i[10:0]] <= mem_wdata_i;
  end
endmodule

`default_nettype wire

// ==== sim/memref_phase_sequencer_tb.sv ====
/*
  Self-checking bench for the memory reference sequencer.
  Assumes the core memory model and the register port header.
*/
`timescale 1ns/10ps
`default_nettype none
`include "memref_regs.svh"

module memref_phase_sequencer_tb
  import memref_pkg::*;
();
  logic        ref_clk_i, rst_i, reg_wr_i, reg_rd_i, mem_read_o, mem_write_o;
  logic [2:0]  reg_addr_i;
  word_t       reg_wdata_i, reg_rdata_o, mem_rdata_i, mem_addr_o, mem_wdata_o;
  logic [1:0]  phase_o;
  period_t     period_o;
  int          n_errors, n_compared, gap;
  word_t       ph_q[$], ad_q[$], gp_q[$], wd_q[$];
  word_t       ra, rb, cur_pc, s;

  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  memref_phase_sequencer u_memref_phase_sequencer (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_rdata_i(mem_rdata_i),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_read_o(mem_read_o),
    .mem_write_o(mem_write_o), .phase_o(phase_o), .period_o(period_o));

  core_memory_model u_core_memory_model (.ref_clk_i(ref_clk_i), .mem_read_i(mem_read_o),
    .mem_write_i(mem_write_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .mem_rdata_o(mem_rdata_i));

  // ----------------------------------------------------------------------
  // monitor: one entry per phase, taken at its read strobe
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (mem_read_o === 1'b1)
    begin
      ph_q.push_back({14'h0, phase_o});
      ad_q.push_back(mem_addr_o);
      gp_q.push_back(word_t'(gap));
      gap = 1;
    end
    else
      gap = gap + 1;
    if (period_o === 3'h2)
      wd_q.push_back(mem_wdata_o);
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  function automatic word_t ins(input logic [3:0] op, input logic ind, input logic pg,
                                input logic [9:0] a);
    ins = {ind, op, pg, a};
  endfunction

  task automatic chk(input word_t got, input word_t exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [2:0] a, input word_t d);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic reg_read(input logic [2:0] a, output word_t d);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    @(posedge ref_clk_i);
    d = reg_rdata_o;
  endtask

  // halting takes effect only at the start of a fetch, so words after the program stay
  // zero and run as fetch-only steps; results are judged from the monitor
  task automatic run(input word_t pc, w, ea, d, a, b, input int n);
    int i;
    u_core_memory_model.mem[pc[10:0]] = w;
    u_core_memory_model.mem[ea[10:0]] = d;
    cur_pc = pc;
    reg_write(`REG_PC, pc);
    reg_write(`REG_ACCA, a);
    reg_write(`REG_ACCB, b);
    ph_q.delete();
    ad_q.delete();
    gp_q.delete();
    wd_q.delete();
    reg_write(`REG_CTRL, 16'h0001);
    reg_write(`REG_ACCB, 16'hdead);
    i = 0;
    while (ad_q.size() < n + 4 && i < 2000)
    begin
      @(posedge ref_clk_i);
      i++;
    end
    chk(word_t'(ad_q.size()), word_t'(n + 4));
    reg_write(`REG_CTRL, 16'h0000);
    s = 16'h0000;
    i = 0;
    while (s[`STAT_IDLE] !== 1'b1 && i < 40)
    begin
      reg_read(`REG_STAT, s);
      i++;
    end
    chk({15'h0, s[`STAT_IDLE]}, 16'h0001);
    reg_read(`REG_ACCA, ra);
    reg_read(`REG_ACCB, rb);
  endtask

  task automatic chk_flow(input int n, input word_t ea, nxt, gx, input string name);
    int i;
    chk(ph_q[0], {14'h0, PH_FETCH});
    chk(ad_q[0], cur_pc);
    for (i = 1; i <= n; i++)
      chk(ph_q[i], {14'h0, PH_IND});
    chk(ph_q[n+1], {14'h0, PH_EXEC});
    chk(ad_q[n+1], ea);
    chk(gp_q[n+1], 16'h0008);
    chk(ph_q[n+2], {14'h0, PH_FETCH});
    chk(ad_q[n+2], nxt);
    chk(gp_q[n+2], gx);
    chk(ad_q[n+3], nxt + 16'h0001);
    $display("test %s done", name);
  endtask

  // skip 3 marks a jump: the next fetch follows the target, not the counter
  task automatic t(input logic [3:0] op, input int k, input word_t a, b, d, xa, xb, xm,
                   input logic [1:0] skip, input word_t gx, input string name);
    word_t pc, ea, nxt;
    pc  = 16'h0100 + word_t'(k * 16);
    ea  = 16'h0300 + word_t'(k);
    nxt = (skip == 2'd3) ? ea + 16'h0001 : pc + 16'h0001 + {14'h0, skip};
    run(pc, ins(op, 1'b0, 1'b0, ea[9:0]), ea, d, a, b, 0);
    chk(ra, xa);
    chk(rb, xb);
    chk(u_core_memory_model.mem[ea[10:0]], xm);
    chk_flow(0, ea, nxt, gx, name);
  endtask

  // ----------------------------------------------------------------------
  // stop and watchdog
  // ----------------------------------------------------------------------
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // the whole sequence needs under a thousand cycles; this is far above it
  initial
  begin
    #(40 * 20000);
    n_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst_i       = 1'b1;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_addr_i  = 3'h0;
    reg_wdata_i = 16'h0000;
    n_errors    = 0;
    n_compared  = 0;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    reg_write(3'h7, 16'hffff);
    reg_write(`REG_STAT, 16'hffff);
    for (int i = 2; i < 8; i++)
    begin
      reg_read(3'(i), s);
      chk(s, `WORD_RST);
    end
    reg_read(`REG_STAT, s);
    chk({14'h0, s[1:0]}, {14'h0, PH_FETCH});
    $display("test reset_values done");

    run(16'h0410, ins(`OP_AND, 1'b0, 1'b0, 10'h030), 16'h0030, 16'h0ff0, 16'h3c3c,
        16'h0000, 0);
    chk(ra, 16'h0c30);
    chk_flow(0, 16'h0030, 16'h0411, 16'h0008, "and_zero_page");

    u_core_memory_model.mem[11'h450] = 16'h8460;
    u_core_memory_model.mem[11'h460] = 16'h0070;
    run(16'h0420, ins(`OP_AND, 1'b1, 1'b1, 10'h050), 16'h0070, 16'h00ff, 16'h0f0f,
        16'h0000, 2);
    chk(ra, 16'h000f);
    chk(ad_q[1], 16'h0450);
    chk(ad_q[2], 16'h8460);
    chk(wd_q[1], 16'h0000);
    chk(wd_q[3], 16'h0000);
    chk_flow(2, 16'h0070, 16'h0421, 16'h0008, "and_indirect_chain");

    // 16'h0015 is eight periods plus the thirteen inserted write cycles
    t(`OP_XOR, 1, 16'haaaa, 16'h0000, 16'hffff, 16'h5555, 16'h0000, 16'hffff, 2'd0,
      16'h0008, "xor");
    t(`OP_ORIN, 2, 16'h00f0, 16'h0000, 16'h0f00, 16'h0ff0, 16'h0000, 16'h0f00, 2'd0,
      16'h0008, "ior");
    t({`OPG_ADD, 1'b0}, 3, 16'h1234, 16'h0001, 16'h1111, 16'h2345, 16'h0001, 16'h1111,
      2'd0, 16'h0008, "add_a");
    t({`OPG_ADD, 1'b1}, 4, 16'h1234, 16'hfffe, 16'h0003, 16'h1234, 16'h0001, 16'h0003,
      2'd0, 16'h0008, "add_b");
    t({`OPG_CMP, 1'b0}, 5, 16'h5a5a, 16'h0000, 16'h5a5a, 16'h5a5a, 16'h0000, 16'h5a5a,
      2'd0, 16'h0008, "cmp_a_equal");
    t({`OPG_CMP, 1'b1}, 6, 16'h0000, 16'h1234, 16'h1235, 16'h0000, 16'h1234, 16'h1235,
      2'd1, 16'h0008, "cmp_b_differ");
    t({`OPG_LOAD, 1'b0}, 7, 16'h0000, 16'h0000, 16'hbeef, 16'hbeef, 16'h0000, 16'hbeef,
      2'd0, 16'h0008, "load_a");
    t({`OPG_LOAD, 1'b1}, 8, 16'h0000, 16'h0000, 16'hbeef, 16'h0000, 16'hbeef, 16'hbeef,
      2'd0, 16'h0008, "load_b");
    t({`OPG_STORE, 1'b0}, 9, 16'h5a5a, 16'h0000, 16'h1111, 16'h5a5a, 16'h0000, 16'h5a5a,
      2'd0, 16'h0008, "store_a");
    t({`OPG_STORE, 1'b1}, 10, 16'h0000, 16'ha5a5, 16'h1111, 16'h0000, 16'ha5a5, 16'ha5a5,
      2'd0, 16'h0008, "store_b");
    t(`OP_JSUB, 11, 16'h0000, 16'h0000, 16'h7777, 16'h0000, 16'h0000, 16'h01b1, 2'd3,
      16'h0008, "jump_subroutine");
    t(`OP_INCSKP, 12, 16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000, 2'd1,
      16'h0015, "incskp_rollover");
    t(`OP_INCSKP, 13, 16'h0000, 16'h0000, 16'h0041, 16'h0000, 16'h0000, 16'h0042, 2'd0,
      16'h0015, "incskp_plain");
    stop_test();
  end
endmodule

`default_nettype wire
